// ==== rtl/plb_defines.svh ====
// constants of the loopback control block: register offsets, field positions, reset and program values
// assumes it is included by bare name wherever a constant is needed
`ifndef PLB_DEFINES_SVH
`define PLB_DEFINES_SVH
// ************************************************************
// management register offsets, standard space
// ************************************************************
`define PLB_REG_BC 5'h00
`define PLB_REG_ADV 5'h04
`define PLB_REG_MS 5'h09
`define PLB_REG_RLB 5'h11
`define PLB_REG_EXT 5'h12
`define PLB_REG_STAT 5'h1f
// ************************************************************
// tuning registers of the vendor space
// ************************************************************
`define PLB_TUNE_15 5'h15
`define PLB_TUNE_16 5'h16
`define PLB_TUNE_18 5'h18
`define PLB_TUNE_1B 5'h1b
// ************************************************************
// field positions
// ************************************************************
`define PLB_BC_LOOP 14
`define PLB_BC_SPD6 6
`define PLB_BC_SPD13 13
`define PLB_BC_AN 12
`define PLB_BC_FD 8
`define PLB_MS_MAN 12
`define PLB_MS_MASTER 11
`define PLB_RLB_EN 8
`define PLB_EXT_EN 0
`define PLB_ST_NEAR 0
`define PLB_ST_FAR 1
`define PLB_ST_EXT 2
`define PLB_ST_LINK 3
`define PLB_ST_SPD 4
// ************************************************************
// reset and program values
// ************************************************************
`define PLB_BC_RST 16'h1140
`define PLB_ADV_VAL 16'h01e1
`define PLB_TUNE_VAL 16'heeee
`define PLB_BC_EXT1000 16'h0140
`define PLB_IDLE_BYTE 8'h00
// ************************************************************
// controller user registers and control fields
// ************************************************************
`define PLB_H_CTRL 2'h0
`define PLB_H_STAT 2'h1
`define PLB_H_RDCMD 2'h2
`define PLB_H_RDDATA 2'h3
`define PLB_C_AN 4
`define PLB_C_GO 15
`define PLB_RC_MMD 5
`endif

// ==== rtl/plb_pkg.sv ====
// types and shared helpers of the loopback control block
// assumes plb_defines.svh is on the include path
`include "plb_defines.svh"
package plb_pkg;
  typedef enum logic [1:0] {PLB_NEAR, PLB_FAR, PLB_EXT, PLB_OFF} plb_mode_t;
  typedef enum logic [1:0] {PLB_S10, PLB_S100, PLB_S1000, PLB_SRSV} plb_speed_t;
  typedef enum logic [1:0] {PLB_IDLE, PLB_STEP, PLB_RD, PLB_CAP} plb_state_t;
  typedef struct packed {
    logic valid;
    logic wait_link;
    logic mmd;
    logic [4:0] addr;
    logic [15:0] data;
  } plb_op_t;

  function automatic logic [15:0] plb_bit(input int n);
    plb_bit = 16'h0001 << n;
  endfunction : plb_bit

  // bit 6 is the high bit of the pattern, bit 13 the low bit
  function automatic plb_speed_t plb_speed(input logic [15:0] bc);
    plb_speed = plb_speed_t'({bc[`PLB_BC_SPD6], bc[`PLB_BC_SPD13]});
  endfunction : plb_speed

  function automatic logic [15:0] plb_spd_bits(input plb_speed_t s);
    plb_spd_bits = (s == PLB_S1000) ? plb_bit(`PLB_BC_SPD6) :
                   (s == PLB_S100) ? plb_bit(`PLB_BC_SPD13) : 16'h0000;
  endfunction : plb_spd_bits
endpackage : plb_pkg

// ==== rtl/plb_link_if.sv ====
// carrier between the transceiver end and the controller/mac end
// assumes one clock for all signals; line signals are driven by the link partner model
`timescale 1ns/1ps
interface plb_link_if (
  input wire logic clk
);
  logic [4:0] mgmt_addr;
  logic mgmt_mmd;
  logic [15:0] mgmt_wdata;
  logic mgmt_we;
  logic mgmt_re;
  logic [15:0] mgmt_rdata;
  logic [7:0] mac_tx_data;
  logic mac_tx_en;
  logic [7:0] mac_rx_data;
  logic mac_rx_dv;
  logic [7:0] line_rx_data;
  logic line_rx_dv;
  logic [7:0] line_tx_data;
  logic line_tx_en;
  logic line_an_1000fd;

  modport phy (
    input mgmt_addr, mgmt_mmd, mgmt_wdata, mgmt_we, mgmt_re,
    output mgmt_rdata,
    input mac_tx_data, mac_tx_en,
    output mac_rx_data, mac_rx_dv,
    input line_rx_data, line_rx_dv, line_an_1000fd,
    output line_tx_data, line_tx_en
  );
  modport mac (
    output mgmt_addr, mgmt_mmd, mgmt_wdata, mgmt_we, mgmt_re,
    input mgmt_rdata,
    output mac_tx_data, mac_tx_en,
    input mac_rx_data, mac_rx_dv
  );
endinterface : plb_link_if

// ==== rtl/plb_phy.sv ====
// transceiver end: management registers and the loopback data paths
// assumes mac and line streams are synchronous to clk, one byte per cycle
`timescale 1ns/1ps
`include "plb_defines.svh"
module plb_phy (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  plb_link_if.phy lnk,
  output logic near_active,
  output logic far_active,
  output logic ext_active
);
  logic [15:0] bc_r, bc_nxt, adv_r, adv_nxt, ms_r, ms_nxt, rlb_r, rlb_nxt, ext_r, ext_nxt;
  logic [15:0] tune_r [4];
  logic [15:0] tune_nxt [4];
  logic [15:0] rdata_r, rdata_nxt;
  logic [7:0] mrx_data_r, mrx_data_nxt, ltx_data_r, ltx_data_nxt;
  logic mrx_dv_r, mrx_dv_nxt, ltx_en_r, ltx_en_nxt;
  logic near_r, near_nxt, far_r, far_nxt, ext_act_r, ext_act_nxt;
  logic far_ok;
  logic [2:0] tsel;
  plb_pkg::plb_speed_t spd;

  // ************************************************************
  // tuning register decode
  // ************************************************************
  function automatic logic [2:0] tune_sel(input logic [4:0] a);
    case (a)
      `PLB_TUNE_15: tune_sel = 3'h4;
      `PLB_TUNE_16: tune_sel = 3'h5;
      `PLB_TUNE_18: tune_sel = 3'h6;
      `PLB_TUNE_1B: tune_sel = 3'h7;
      default: tune_sel = 3'h0;
    endcase
  endfunction : tune_sel

  // ************************************************************
  // registers and data paths, next values
  // ************************************************************
  always_comb begin
    bc_nxt = bc_r;
    adv_nxt = adv_r;
    ms_nxt = ms_r;
    rlb_nxt = rlb_r;
    ext_nxt = ext_r;
    tune_nxt = tune_r;
    rdata_nxt = 16'h0000;
    tsel = tune_sel(lnk.mgmt_addr);
    spd = plb_pkg::plb_speed(bc_r);
    if (lnk.mgmt_we) begin
      if (lnk.mgmt_mmd) begin
        if (tsel[2]) begin
          tune_nxt[tsel[1:0]] = lnk.mgmt_wdata;
        end
      end else begin
        case (lnk.mgmt_addr)
          `PLB_REG_BC: bc_nxt = lnk.mgmt_wdata;
          `PLB_REG_ADV: adv_nxt = lnk.mgmt_wdata;
          `PLB_REG_MS: ms_nxt = lnk.mgmt_wdata;
          `PLB_REG_RLB: rlb_nxt = lnk.mgmt_wdata;
          `PLB_REG_EXT: ext_nxt = lnk.mgmt_wdata;
          default: ;
        endcase
      end
    end
    if (lnk.mgmt_re) begin
      if (lnk.mgmt_mmd) begin
        if (tsel[2]) begin
          rdata_nxt = tune_r[tsel[1:0]];
        end
      end else begin
        case (lnk.mgmt_addr)
          `PLB_REG_BC: rdata_nxt = bc_r;
          `PLB_REG_ADV: rdata_nxt = adv_r;
          `PLB_REG_MS: rdata_nxt = ms_r;
          `PLB_REG_RLB: rdata_nxt = rlb_r;
          `PLB_REG_EXT: rdata_nxt = ext_r;
          `PLB_REG_STAT: begin
            rdata_nxt[`PLB_ST_NEAR] = near_r;
            rdata_nxt[`PLB_ST_FAR] = far_r;
            rdata_nxt[`PLB_ST_EXT] = ext_act_r;
            rdata_nxt[`PLB_ST_LINK] = lnk.line_an_1000fd;
            rdata_nxt[`PLB_ST_SPD +: 2] = spd;
          end
          default: rdata_nxt = 16'h0000;
        endcase
      end
    end

    // near-end wrap at any speed, but full duplex only
    near_nxt = bc_r[`PLB_BC_LOOP] & bc_r[`PLB_BC_FD];
    // far-end needs 1000 full duplex, forced or negotiated
    far_ok = bc_r[`PLB_BC_AN] ? lnk.line_an_1000fd : (bc_r[`PLB_BC_FD] && spd == plb_pkg::PLB_S1000);
    far_nxt = rlb_r[`PLB_RLB_EN] & far_ok & ~near_nxt;
    // the cable does the wrap; the device keeps normal paths at any speed
    ext_act_nxt = ext_r[`PLB_EXT_EN] & ~near_nxt & ~far_nxt;

    // mac receive side: wrapped transmit stream or line data
    mrx_data_nxt = near_r ? lnk.mac_tx_data : lnk.line_rx_data;
    mrx_dv_nxt = near_r ? lnk.mac_tx_en : lnk.line_rx_dv;
    // line side is idle under near-end so the partner sees no stray frames
    if (far_r) begin
      ltx_data_nxt = lnk.line_rx_data;
      ltx_en_nxt = lnk.line_rx_dv;
    end else if (near_r) begin
      ltx_data_nxt = `PLB_IDLE_BYTE;
      ltx_en_nxt = 1'b0;
    end else begin
      ltx_data_nxt = lnk.mac_tx_data;
      ltx_en_nxt = lnk.mac_tx_en;
    end
  end

  // ************************************************************
  // state
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bc_r <= `PLB_BC_RST;
      adv_r <= `PLB_ADV_VAL;
      ms_r <= 16'h0000;
      rlb_r <= 16'h0000;
      ext_r <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        tune_r[i] <= 16'h0000;
      end
      rdata_r <= 16'h0000;
      mrx_data_r <= 8'h00;
      mrx_dv_r <= 1'b0;
      ltx_data_r <= 8'h00;
      ltx_en_r <= 1'b0;
      near_r <= 1'b0;
      far_r <= 1'b0;
      ext_act_r <= 1'b0;
    end else if (ce) begin
      bc_r <= bc_nxt;
      adv_r <= adv_nxt;
      ms_r <= ms_nxt;
      rlb_r <= rlb_nxt;
      ext_r <= ext_nxt;
      tune_r <= tune_nxt;
      rdata_r <= rdata_nxt;
      mrx_data_r <= mrx_data_nxt;
      mrx_dv_r <= mrx_dv_nxt;
      ltx_data_r <= ltx_data_nxt;
      ltx_en_r <= ltx_en_nxt;
      near_r <= near_nxt;
      far_r <= far_nxt;
      ext_act_r <= ext_act_nxt;
    end
  end

  assign lnk.mgmt_rdata = rdata_r;
  assign lnk.mac_rx_data = mrx_data_r;
  assign lnk.mac_rx_dv = mrx_dv_r;
  assign lnk.line_tx_data = ltx_data_r;
  assign lnk.line_tx_en = ltx_en_r;
  assign near_active = near_r;
  assign far_active = far_r;
  assign ext_active = ext_act_r;
endmodule : plb_phy

// ==== rtl/plb_ctl.sv ====
// controller end: sequences the management writes for each loopback mode and carries the mac stream
// assumes the transceiver end answers a management read one cycle after the read strobe
//
// Summary of operation
// - near-end wrap at every speed, full duplex
// - near-end returns mac frames to mac
// - write eeee to four tuning registers first
// - set basic control bit 14 for near-end
// - bits 6 and 13 select the speed
// - forced modes: negotiation off, full duplex on
// - gigabit near-end: manual config, slave role
// - far-end wrap only at gigabit full duplex
// - far-end enabled by remote loopback bit 8
// - far-end may use negotiated gigabit link instead
// - connector loopback works at every speed
// - connector mode set via control, advertisement, master-slave
// - gigabit connector: 0140h, master, then enable
`timescale 1ns/1ps
`include "plb_defines.svh"
module plb_ctl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [15:0] rdata,
  input wire logic [7:0] tx_data,
  input wire logic tx_en,
  output logic [7:0] rx_data,
  output logic rx_dv,
  plb_link_if.mac lnk
);
  plb_pkg::plb_state_t st_r, st_nxt;
  plb_pkg::plb_mode_t mode_r, mode_nxt;
  plb_pkg::plb_speed_t spd_r, spd_nxt;
  logic an_r, an_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic done_r, done_nxt;
  logic usr_rd_r, usr_rd_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [4:0] m_addr_r, m_addr_nxt;
  logic m_mmd_r, m_mmd_nxt;
  logic [15:0] m_wdata_r, m_wdata_nxt;
  logic m_we_r, m_we_nxt;
  logic m_re_r, m_re_nxt;
  logic [7:0] tx_data_r, rx_data_r;
  logic tx_en_r, rx_dv_r;
  plb_pkg::plb_op_t op;

  // ************************************************************
  // program of management accesses for one mode
  // ************************************************************
  function automatic plb_pkg::plb_op_t op_of(input plb_pkg::plb_mode_t m, input plb_pkg::plb_speed_t s,
                                             input logic an, input logic [2:0] i);
    plb_pkg::plb_op_t o;
    logic g;
    logic [15:0] sb;
    o = '0;
    g = (s == plb_pkg::PLB_S1000);
    sb = plb_pkg::plb_spd_bits(s);
    o.valid = 1'b1;
    o.addr = `PLB_REG_BC;
    case (m)
      plb_pkg::PLB_NEAR: begin
        o.mmd = (i < 3'h4);
        o.data = `PLB_TUNE_VAL;
        case (i)
          3'h0: o.addr = `PLB_TUNE_15;
          3'h1: o.addr = `PLB_TUNE_16;
          3'h2: o.addr = `PLB_TUNE_18;
          3'h3: o.addr = `PLB_TUNE_1B;
          // loop on, speed pattern, negotiation off, full duplex
          3'h4: o.data = plb_pkg::plb_bit(`PLB_BC_LOOP) | sb | plb_pkg::plb_bit(`PLB_BC_FD);
          3'h5: begin
            o.valid = g;
            o.addr = `PLB_REG_MS;
            o.data = plb_pkg::plb_bit(`PLB_MS_MAN); // manual, role bit left clear for slave
          end
          default: o.valid = 1'b0;
        endcase
      end
      plb_pkg::PLB_FAR: begin
        case (an ? i : i + 3'h1)
          // negotiation on and wait for a gigabit full duplex link
          3'h0: o.data = plb_pkg::plb_bit(`PLB_BC_AN) | plb_pkg::plb_bit(`PLB_BC_SPD6) | plb_pkg::plb_bit(`PLB_BC_FD);
          3'h1: begin
            if (an) begin
              o.wait_link = 1'b1;
              o.addr = `PLB_REG_STAT;
            end else begin
              o.data = plb_pkg::plb_bit(`PLB_BC_SPD6) | plb_pkg::plb_bit(`PLB_BC_FD);
            end
          end
          3'h2: begin
            o.addr = `PLB_REG_RLB;
            o.data = plb_pkg::plb_bit(`PLB_RLB_EN); // only after gigabit full duplex is set
          end
          default: o.valid = 1'b0;
        endcase
      end
      plb_pkg::PLB_EXT: begin
        case (i)
          3'h0: begin
            o.addr = g ? `PLB_REG_BC : `PLB_REG_ADV;
            o.data = g ? `PLB_BC_EXT1000 : `PLB_ADV_VAL;
          end
          3'h1: begin
            o.addr = g ? `PLB_REG_MS : `PLB_REG_BC;
            // manual master in gigabit, else the chosen speed at full duplex
            o.data = g ? (plb_pkg::plb_bit(`PLB_MS_MAN) | plb_pkg::plb_bit(`PLB_MS_MASTER))
                       : (sb | plb_pkg::plb_bit(`PLB_BC_FD));
          end
          3'h2: begin
            o.addr = `PLB_REG_EXT;
            o.data = plb_pkg::plb_bit(`PLB_EXT_EN); // last of the ordered writes
          end
          default: o.valid = 1'b0;
        endcase
      end
      plb_pkg::PLB_OFF: begin
        case (i)
          3'h0: o.addr = `PLB_REG_RLB; // enables cleared first so no frame is wrapped
          3'h1: o.addr = `PLB_REG_EXT;
          3'h2: o.data = sb | plb_pkg::plb_bit(`PLB_BC_FD); // loop bit clear
          default: o.valid = 1'b0;
        endcase
      end
      default: o.valid = 1'b0;
    endcase
    op_of = o;
  endfunction : op_of

  // ************************************************************
  // sequencer and user registers, next values
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    spd_nxt = spd_r;
    an_nxt = an_r;
    idx_nxt = idx_r;
    done_nxt = done_r;
    usr_rd_nxt = usr_rd_r;
    rd_valid_nxt = rd_valid_r;
    rd_data_nxt = rd_data_r;
    rdata_nxt = 16'h0000;
    m_addr_nxt = m_addr_r;
    m_mmd_nxt = m_mmd_r;
    m_wdata_nxt = m_wdata_r;
    m_we_nxt = 1'b0;
    m_re_nxt = 1'b0;
    op = op_of(mode_r, spd_r, an_r, idx_r);
    case (st_r)
      plb_pkg::PLB_IDLE: begin
        // commands while busy are dropped, so a running sequence keeps its order
        if (we && addr == `PLB_H_CTRL && wdata[`PLB_C_GO]) begin
          mode_nxt = plb_pkg::plb_mode_t'(wdata[1:0]);
          spd_nxt = plb_pkg::plb_speed_t'(wdata[3:2]);
          an_nxt = wdata[`PLB_C_AN];
          idx_nxt = 3'h0;
          done_nxt = 1'b0;
          st_nxt = plb_pkg::PLB_STEP;
        end else if (we && addr == `PLB_H_RDCMD) begin
          usr_rd_nxt = 1'b1;
          rd_valid_nxt = 1'b0;
          m_addr_nxt = wdata[4:0];
          m_mmd_nxt = wdata[`PLB_RC_MMD];
          m_re_nxt = 1'b1;
          st_nxt = plb_pkg::PLB_RD;
        end
      end
      plb_pkg::PLB_STEP: begin
        m_addr_nxt = op.addr;
        m_mmd_nxt = op.mmd;
        m_wdata_nxt = op.data;
        if (!op.valid) begin
          done_nxt = 1'b1;
          st_nxt = plb_pkg::PLB_IDLE;
        end else if (op.wait_link) begin
          m_re_nxt = 1'b1;
          st_nxt = plb_pkg::PLB_RD;
        end else begin
          m_we_nxt = 1'b1; // one write per cycle, in table order
          idx_nxt = idx_r + 3'h1;
        end
      end
      plb_pkg::PLB_RD: st_nxt = plb_pkg::PLB_CAP;
      plb_pkg::PLB_CAP: begin
        if (usr_rd_r) begin
          usr_rd_nxt = 1'b0;
          rd_valid_nxt = 1'b1;
          rd_data_nxt = lnk.mgmt_rdata;
          st_nxt = plb_pkg::PLB_IDLE;
        end else if (lnk.mgmt_rdata[`PLB_ST_LINK]) begin
          idx_nxt = idx_r + 3'h1; // link is up, go on to the enable
          st_nxt = plb_pkg::PLB_STEP;
        end else begin
          m_re_nxt = 1'b1; // poll again, no time limit
          st_nxt = plb_pkg::PLB_RD;
        end
      end
      default: st_nxt = plb_pkg::PLB_IDLE;
    endcase
    if (re) begin
      case (addr)
        `PLB_H_CTRL: rdata_nxt = {11'h000, an_r, 4'h0} | {12'h000, spd_r, mode_r};
        `PLB_H_STAT: rdata_nxt = {13'h0000, rd_valid_r, done_r, st_r != plb_pkg::PLB_IDLE};
        `PLB_H_RDDATA: rdata_nxt = rd_data_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // state
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= plb_pkg::PLB_IDLE;
      mode_r <= plb_pkg::PLB_OFF;
      spd_r <= plb_pkg::PLB_S1000;
      an_r <= 1'b0;
      idx_r <= 3'h0;
      done_r <= 1'b0;
      usr_rd_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 16'h0000;
      rdata_r <= 16'h0000;
      m_addr_r <= 5'h00;
      m_mmd_r <= 1'b0;
      m_wdata_r <= 16'h0000;
      m_we_r <= 1'b0;
      m_re_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_en_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_dv_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      spd_r <= spd_nxt;
      an_r <= an_nxt;
      idx_r <= idx_nxt;
      done_r <= done_nxt;
      usr_rd_r <= usr_rd_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      rdata_r <= rdata_nxt;
      m_addr_r <= m_addr_nxt;
      m_mmd_r <= m_mmd_nxt;
      m_wdata_r <= m_wdata_nxt;
      m_we_r <= m_we_nxt;
      m_re_r <= m_re_nxt;
      tx_data_r <= tx_data;
      tx_en_r <= tx_en;
      rx_data_r <= lnk.mac_rx_data;
      rx_dv_r <= lnk.mac_rx_dv;
    end
  end

  assign rdata = rdata_r;
  assign rx_data = rx_data_r;
  assign rx_dv = rx_dv_r;
  assign lnk.mgmt_addr = m_addr_r;
  assign lnk.mgmt_mmd = m_mmd_r;
  assign lnk.mgmt_wdata = m_wdata_r;
  assign lnk.mgmt_we = m_we_r;
  assign lnk.mgmt_re = m_re_r;
  assign lnk.mac_tx_data = tx_data_r;
  assign lnk.mac_tx_en = tx_en_r;
endmodule : plb_ctl

// ==== verif/plb_link_monitor.sv ====
// checker of the link between the transceiver end and the controller end
// assumes it sits beside plb_link_if, all signals on clk
`timescale 1ns/1ps
`include "plb_defines.svh"
module plb_mon (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_mmd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_we,
  input wire logic [7:0] mac_tx_data,
  input wire logic mac_tx_en,
  input wire logic [7:0] mac_rx_data,
  input wire logic mac_rx_dv,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_dv,
  input wire logic [7:0] line_tx_data,
  input wire logic line_tx_en,
  input wire logic line_an_1000fd
);
  // ************************************************************
  // shadow registers
  // ************************************************************
  // mode copied from the bus so the wrap checks need no view inside the transceiver
  logic [15:0] bc_r, ms_r, rlb_r;
  logic [2:0] tune_r;
  logic near_q, far_q;
  wire wb = mgmt_we && !mgmt_mmd;
  wire bc_w = wb && mgmt_addr == `PLB_REG_BC;
  wire gig = bc_r[8] && bc_r[6] && !bc_r[13];
  wire near_c = bc_r[14] && bc_r[8];
  wire far_c = rlb_r[8] && (bc_r[12] ? line_an_1000fd : gig) && !near_c;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bc_r <= `PLB_BC_RST;
      ms_r <= 16'h0000;
      rlb_r <= 16'h0000;
      tune_r <= 3'h0;
      near_q <= 1'b0;
      far_q <= 1'b0;
    end else begin
      if (bc_w) bc_r <= mgmt_wdata;
      if (wb && mgmt_addr == `PLB_REG_MS) ms_r <= mgmt_wdata;
      if (wb && mgmt_addr == `PLB_REG_RLB) rlb_r <= mgmt_wdata;
      if (mgmt_we) tune_r <= (mgmt_mmd && mgmt_wdata == `PLB_TUNE_VAL) ? tune_r + 3'h1 : 3'h0;
      near_q <= near_c;
      far_q <= far_c;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_near_wrap: assert property (near_q && mac_tx_en |=> mac_rx_dv && mac_rx_data == $past(mac_tx_data))
    else $error("near wrap lost a byte");
  a_near_quiet: assert property (near_q |=> !line_tx_en)
    else $error("line sent during near wrap");
  a_far_wrap: assert property (far_q && line_rx_dv |=> line_tx_en && line_tx_data == $past(line_rx_data))
    else $error("far wrap lost a byte");
  a_normal_tx: assert property (!near_q && !far_q && mac_tx_en |=> line_tx_en && line_tx_data == $past(mac_tx_data))
    else $error("normal transmit path broken");
  a_normal_rx: assert property (!near_q && line_rx_dv |=> mac_rx_dv && mac_rx_data == $past(line_rx_data))
    else $error("normal receive path broken");
  a_tune_first: assert property (bc_w && mgmt_wdata[14] |-> tune_r == 3'h4)
    else $error("loop enabled before four tuning writes");
  a_near_fields: assert property (bc_w && mgmt_wdata[14] |-> !mgmt_wdata[12] && mgmt_wdata[8]
    && !(mgmt_wdata[6] && mgmt_wdata[13])) else $error("near loop control fields wrong");
  a_gig_slave: assert property (bc_w && mgmt_wdata[14] && mgmt_wdata[6] |-> ##[1:4]
    (wb && mgmt_addr == `PLB_REG_MS && mgmt_wdata[12] && !mgmt_wdata[11])) else $error("no manual slave write");
  a_far_setup: assert property (wb && mgmt_addr == `PLB_REG_RLB && mgmt_wdata[8]
    |-> gig || bc_r[12] && line_an_1000fd) else $error("far loop enabled without gigabit full duplex");
  a_ext_order: assert property (wb && mgmt_addr == `PLB_REG_EXT && mgmt_wdata[0] && bc_r[6]
    |-> bc_r == `PLB_BC_EXT1000 && ms_r[12:11] == 2'b11) else $error("connector loop order wrong");
  c_near: cover property (near_q && mac_tx_en);
  c_far: cover property (far_q && line_rx_dv);
  c_ext: cover property (wb && mgmt_addr == `PLB_REG_EXT && mgmt_wdata[0]);
endmodule : plb_mon

// ==== verif/tb.sv ====
// testbench: controller and transceiver joined by plb_link_if, user port and line side driven here
// assumes one 200 MHz clock; line partner is played by this bench
`timescale 1ns/1ps
`include "plb_defines.svh"
module tb;
  logic clk, arst_n, ce, we, re, tx_en, rx_dv, near_a, far_a, ext_a;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, s;
  logic [7:0] tx_data, rx_data;
  logic [31:0] rnd;
  logic [15:0] q_mac[$], q_line[$];
  int err_total, tests_run, md, i, k;
  // ************************************************************
  // mode table: control word, basic control, second register, flags
  // ************************************************************
  logic [15:0] t_ctl[9] = '{16'h0000, 16'h0004, 16'h0008, 16'h0009, 16'h0019, 16'h000b, 16'h000a, 16'h0006, 16'h000b};
  logic [15:0] t_bc[9] = '{16'h4100, 16'h6100, 16'h4140, 16'h0140, 16'h1140, 16'h0140, 16'h0140, 16'h2100, 16'h0140};
  logic [4:0] t_ra[9] = '{`PLB_REG_STAT, `PLB_REG_STAT, `PLB_REG_MS, `PLB_REG_RLB, `PLB_REG_RLB, `PLB_REG_RLB,
    `PLB_REG_MS, `PLB_REG_ADV, `PLB_REG_EXT};
  logic [15:0] t_rv[9] = '{16'h0001, 16'h0011, 16'h1000, 16'h0100, 16'h0100, 16'h0000, 16'h1800, 16'h01e1, 16'h0000};
  logic [2:0] t_fl[9] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h4, 3'h4, 3'h0};
  logic [4:0] t_tune[4] = '{`PLB_TUNE_15, `PLB_TUNE_16, `PLB_TUNE_18, `PLB_TUNE_1B};
  plb_link_if lnk (.clk(clk));
  plb_phy u_plb_phy (.clk(clk), .arst_n(arst_n), .ce(ce), .lnk(lnk), .near_active(near_a), .far_active(far_a),
    .ext_active(ext_a));
  plb_ctl u_plb_ctl (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .tx_data(tx_data), .tx_en(tx_en), .rx_data(rx_data), .rx_dv(rx_dv), .lnk(lnk));
  plb_mon u_plb_mon (.clk(clk), .arst_n(arst_n), .mgmt_addr(lnk.mgmt_addr), .mgmt_mmd(lnk.mgmt_mmd),
    .mgmt_wdata(lnk.mgmt_wdata), .mgmt_we(lnk.mgmt_we), .mac_tx_data(lnk.mac_tx_data), .mac_tx_en(lnk.mac_tx_en),
    .mac_rx_data(lnk.mac_rx_data), .mac_rx_dv(lnk.mac_rx_dv), .line_rx_data(lnk.line_rx_data),
    .line_rx_dv(lnk.line_rx_dv), .line_tx_data(lnk.line_tx_data), .line_tx_en(lnk.line_tx_en),
    .line_an_1000fd(lnk.line_an_1000fd));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task test_done;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 s = rdata;
  endtask : rd
  task idle;
    for (int n = 0; n < 300; n++) begin
      rd(`PLB_H_STAT);
      if (s[0] === 1'b0) break;
    end
  endtask : idle
  task preg(input logic [4:0] a, input logic m, input logic [15:0] e);
    wr(`PLB_H_RDCMD, {10'h000, m, a});
    idle;
    rd(`PLB_H_RDDATA);
    chk(s, e);
  endtask : preg
  // expected bytes follow the mode held in md
  task frame(input logic ln);
    repeat (6) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      if (ln) begin
        lnk.line_rx_dv <= 1'b1;
        lnk.line_rx_data <= rnd[7:0];
      end else begin
        tx_en <= 1'b1;
        tx_data <= rnd[7:0];
      end
      if (ln ? md != 0 : md == 0) q_mac.push_back({8'h00, rnd[7:0]});
      if (ln ? md == 1 : md >= 2) q_line.push_back({8'h00, rnd[7:0]});
    end
    @(posedge clk);
    lnk.line_rx_dv <= 1'b0;
    tx_en <= 1'b0;
    lnk.line_rx_data <= ~rnd[7:0];
    tx_data <= ~rnd[7:0];
    repeat (8) @(posedge clk);
  endtask : frame
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // an unexpected byte meets an empty queue and yields ffff, which no byte can match
  always @(negedge clk) begin
    if (rx_dv === 1'b1) chk({8'h00, rx_data}, q_mac.size() ? q_mac.pop_front() : 16'hffff);
    if (lnk.line_tx_en === 1'b1) chk({8'h00, lnk.line_tx_data}, q_line.size() ? q_line.pop_front() : 16'hffff);
  end
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    test_done;
  end
  initial begin
    {arst_n, we, re, addr, wdata, tx_en, tx_data} = '0;
    {lnk.line_rx_dv, lnk.line_rx_data, lnk.line_an_1000fd} = '0;
    ce = 1'b1;
    rnd = 32'h03f66a5f;
    md = 3;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    frame(1'b0);
    frame(1'b1);
    for (k = 0; k < 9; k++) begin
      fork
        begin
          wr(`PLB_H_CTRL, t_ctl[k] | 16'h8000);
          if (k == 2) wr(`PLB_H_CTRL, 16'h8009);
          idle;
        end
        begin
          repeat (40) @(posedge clk);
          lnk.line_an_1000fd <= (k >= 4);
        end
      join
      chk(s & 16'h0003, 16'h0002);
      rd(`PLB_H_CTRL);
      chk(s, t_ctl[k] & 16'h001f);
      chk({13'h0000, ext_a, far_a, near_a}, {13'h0000, t_fl[k]});
      preg(`PLB_REG_BC, 1'b0, t_bc[k]);
      preg(t_ra[k], 1'b0, t_rv[k]);
      md = t_ctl[k][1:0];
      if (md == 0) for (i = 0; i < 4; i++) preg(t_tune[i], 1'b1, `PLB_TUNE_VAL);
      frame(1'b0);
      frame(1'b1);
      $display("test step %0d done", k);
    end
    // a go strobe while the enable is low must be lost: still idle and done
    ce <= 1'b0;
    wr(`PLB_H_CTRL, 16'h8000);
    ce <= 1'b1;
    rd(`PLB_H_STAT);
    chk(s & 16'h0003, 16'h0002);
    chk(16'(q_mac.size() + q_line.size()), 16'h0000);
    test_done;
  end
endmodule : tb
